// *** bench/hfl_frame_ctrl_chk.sv ***
`timescale 1ns/1ps
// watches command answers, hub write gating and the frame sequence
module hfl_frame_ctrl_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire hfl_pkg::hfl_cmd_t CMD,
  input wire logic [31:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic RUN_STATE,
  input wire logic [hfl_pkg::FR_W-1:0] FRAME_INTERVAL,
  input wire logic SOF_REQ,
  input wire logic SOF_DONE,
  input wire logic POST_REQ,
  input wire logic [hfl_pkg::FN_W-1:0] POST_DATA,
  input wire logic POST_ACK,
  input wire logic FRAME_START_SET,
  input wire logic ED_FETCH_OK,
  input wire logic LS_QUERY,
  input wire logic LS_START_OK,
  input wire hfl_pkg::hfl_hub_wr_t HUB_WR
);
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire logic rd_cmd = CMD.valid && !CMD.code[7]; // read taken
  wire logic st_cmd = CMD.valid && CMD.code inside {8'h94, 8'h95, 8'h96}; // hub status write
  chk_rd_answer: assert property (rd_cmd |=> RD_VALID)
    else $error("read not answered");
  chk_hub_word: assert property (CMD.valid && !CMD.dword |=> !HUB_WR.valid)
    else $error("partial hub write taken");
  chk_hub_desc: assert property (CMD.valid && CMD.dword && CMD.code inside {8'h92, 8'h93}
    |=> HUB_WR.valid && HUB_WR.data == $past(CMD.wdata)) else $error("descriptor write lost");
  chk_hub_stopped: assert property (st_cmd && !RUN_STATE |=> !HUB_WR.valid)
    else $error("status write taken when stopped");
  chk_hub_run: assert property (st_cmd && CMD.dword && RUN_STATE
    |=> HUB_WR.valid && HUB_WR.sel == $past(CMD.code[2:0]) - 3'h2) else $error("status write lost");
  chk_post_order: assert property ($rose(POST_REQ) |-> $past(SOF_DONE) && !SOF_REQ)
    else $error("post before token");
  chk_ed_block: assert property (SOF_REQ || POST_REQ |-> !ED_FETCH_OK)
    else $error("descriptor fetch before post");
  chk_flag_delay: assert property (POST_REQ && POST_ACK && RUN_STATE ##1 RUN_STATE |=> FRAME_START_SET)
    else $error("flag not set after post");
  chk_ls_gate: assert property (LS_START_OK |-> LS_QUERY && RUN_STATE)
    else $error("low-speed start without request");
  chk_run_entry: assert property ($rose(RUN_STATE) |-> ##[1:3] SOF_REQ)
    else $error("no frame on running entry");
  chk_ed_entry: assert property ($rose(RUN_STATE) |-> !ED_FETCH_OK)
    else $error("descriptor fetch on running entry");
  cover property (FRAME_START_SET);
  cover property (LS_START_OK);
  cover property (HUB_WR.valid && HUB_WR.sel == 3'h4);
endmodule
bind hfl_frame_ctrl hfl_frame_ctrl_chk u_chk (.CLK_SYS, .RST_N, .CMD, .RD_DATA, .RD_VALID, .RUN_STATE,
  .FRAME_INTERVAL, .SOF_REQ, .SOF_DONE, .POST_REQ, .POST_DATA, .POST_ACK, .FRAME_START_SET,
  .ED_FETCH_OK, .LS_QUERY, .LS_START_OK, .HUB_WR);

// *** bench/hfl_frame_ctrl_tb.sv ***
`timescale 1ns/1ps
// scenario bench: reset values, cutoff register, frames, hub writes
module hfl_frame_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0; // reset, active low
  hfl_pkg::hfl_cmd_t cmd = '0;
  logic run_state = 1'b0;
  logic ls_query = 1'b0;
  logic slow = 1'b0; // partner answers slowly
  logic [hfl_pkg::FR_W-1:0] frame_interval = 14'h0014; // short frames
  logic [31:0] rd_data, got_d;
  logic rd_valid, sof_req, sof_done, post_req, post_ack, frame_start_set, ed_fetch_ok, ls_start_ok, got_v;
  logic [hfl_pkg::FN_W-1:0] post_data;
  hfl_pkg::hfl_hub_wr_t hub_wr, got_h;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  hfl_frame_ctrl DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .CMD(cmd), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .RUN_STATE(run_state), .FRAME_INTERVAL(frame_interval), .SOF_REQ(sof_req), .SOF_DONE(sof_done),
    .POST_REQ(post_req), .POST_DATA(post_data), .POST_ACK(post_ack), .FRAME_START_SET(frame_start_set),
    .ED_FETCH_OK(ed_fetch_ok), .LS_QUERY(ls_query), .LS_START_OK(ls_start_ok), .HUB_WR(hub_wr));
  hfl_link_model u_link (.clk(clk_sys), .rst_n(rst_n), .slow(slow), .sof_req(sof_req),
    .post_req(post_req), .sof_done(sof_done), .post_ack(post_ack));
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one command; the answer is captured the cycle after it is taken
  task automatic send(logic [7:0] code, logic dw, logic [31:0] wd);
    cmd = '{1'b1, code, dw, wd};
    cyc(1);
    got_d = rd_data;
    got_v = rd_valid;
    got_h = hub_wr;
    cmd = '0;
    cyc(1);
  endtask
  task automatic t_reset();
    send(hfl_pkg::CMD_LSC_RD, 1'b1, '0);
    cmp("rd_valid", 32'h1, got_v);
    cmp("cutoff", 32'h628, got_d);
    send(8'h05, 1'b1, '0);
    cmp("unmapped", 32'h0, got_d);
    $display("test reset done");
  endtask
  task automatic t_cutoff();
    int hi = 0;
    send(hfl_pkg::CMD_LSC_WR, 1'b1, 32'hFFFFF123);
    run_state = 1'b1;
    send(hfl_pkg::CMD_LSC_WR, 1'b1, 32'h55);
    send(hfl_pkg::CMD_LSC_RD, 1'b1, '0);
    cmp("cutoff", 32'h123, got_d);
    ls_query = 1'b1;
    repeat (120) begin
      cyc(1);
      cmp("ls_ok", 32'h0, ls_start_ok);
    end
    run_state = 1'b0;
    send(hfl_pkg::CMD_LSC_WR, 1'b1, 32'hA);
    run_state = 1'b1;
    repeat (200) begin
      cyc(1);
      hi += (ls_start_ok === 1'b1);
    end
    cmp("ls_mix", 32'h1, hi > 0 && hi < 200);
    ls_query = 1'b0;
    run_state = 1'b0;
    $display("test cutoff done");
  endtask
  task automatic t_frames();
    logic [31:0] c0;
    send(hfl_pkg::CMD_FN_RD, 1'b1, '0);
    c0 = got_d;
    run_state = 1'b1;
    for (int k = 1; k <= 3; k++) begin
      for (int n = 0; n < 500 && frame_start_set !== 1'b1; n++) cyc(1);
      cmp("post_data", c0 + k, post_data);
      cmp("ed_ok", 32'h1, ed_fetch_ok);
      slow = ~slow;
      cyc(1);
    end
    run_state = 1'b0;
    send(hfl_pkg::CMD_FN_RD, 1'b1, '0);
    cmp("count", c0 + 3, got_d);
    send(hfl_pkg::CMD_FR_RD, 1'b1, '0);
    cmp("fr_range", 32'h1, got_d <= 32'h14);
    $display("test frames done");
  endtask
  task automatic t_hub();
    logic ok;
    for (int r = 0; r < 2; r++) begin
      run_state = r[0];
      for (logic [7:0] c = 8'h92; c <= 8'h96; c++) begin
        send(c, 1'b1, {c, 24'hA55A00});
        ok = (c < 8'h94) || r[0];
        cmp("hub_valid", ok, got_h.valid);
        cmp("hub_sel", ok ? c[2:0] - 3'h2 : 3'h0, got_h.sel);
        cmp("hub_data", ok ? {c, 24'hA55A00} : 32'h00000000, got_h.data);
      end
    end
    send(hfl_pkg::CMD_HUB_DA_WR, 1'b0, 32'h1);
    cmp("hub_part", 32'h0, got_h.valid);
    run_state = 1'b0;
    $display("test hub done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_cutoff();
    t_frames();
    t_hub();
    end_sim();
  end
endmodule

// *** bench/hfl_link_model.sv ***
`timescale 1ns/1ps
// token sender and shared-area memory on the far side of the frame sequence
module hfl_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow, // wait three cycles before answering
  input wire logic sof_req,
  input wire logic post_req,
  output logic sof_done,
  output logic post_ack
);
  int n = 0; // cycles waited on the open request
  int lim = 0; // wait length, taken at the edge so a mode change never races the answer
  // one-cycle answer once the wait is over, then drop it
  always @(posedge clk) begin
    lim = slow ? 3 : 0;
    #1;
    if (!rst_n || sof_done || post_ack) begin
      sof_done = 1'b0;
      post_ack = 1'b0;
      n = 0;
    end else if (n < lim) begin
      n = n + ((sof_req || post_req) ? 1 : 0);
    end else begin
      sof_done = sof_req;
      post_ack = post_req;
    end
  end
endmodule

// *** include/hfl_pkg.sv ***
package hfl_pkg;
  // command codes; bit 7 set marks a write
  localparam logic [7:0] CMD_WR_BIT = 8'h80;
  localparam logic [7:0] CMD_FR_RD = 8'h0E;
  localparam logic [7:0] CMD_FN_RD = 8'h0F;
  localparam logic [7:0] CMD_LSC_RD = 8'h11;
  localparam logic [7:0] CMD_LSC_WR = 8'h91;
  localparam logic [7:0] CMD_HUB_DA_WR = 8'h92;
  localparam logic [7:0] CMD_HUB_DB_WR = 8'h93;
  localparam logic [7:0] CMD_HUB_ST_WR = 8'h94;
  localparam logic [7:0] CMD_HUB_P1_WR = 8'h95;
  localparam logic [7:0] CMD_HUB_P2_WR = 8'h96;
  // field layouts and reset values
  localparam int FN_W = 16;
  localparam int FR_W = 14;
  localparam int LSC_W = 11;
  localparam logic [LSC_W-1:0] LSC_RST = 11'h628;
  localparam logic [FN_W-1:0] FN_RST = 16'h0000;
  localparam logic [FR_W-1:0] FR_RST = 14'h0000;
  // bit-time enable: full-speed 12 MHz derived from 50 MHz by a phase accumulator
  localparam int SYS_CLK_KHZ = 50000;
  localparam int BIT_RATE_KHZ = 12000;
  localparam logic [15:0] BIT_ACC_STEP = 16'(BIT_RATE_KHZ);
  localparam logic [15:0] BIT_ACC_WRAP = 16'(SYS_CLK_KHZ);
  localparam logic [15:0] BIT_ACC_RST = 16'h0000;

  // one register command from the driver
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic dword;
    logic [31:0] wdata;
  } hfl_cmd_t;

  // hub register write forwarded to the root hub block
  typedef struct packed {
    logic valid;
    logic [2:0] sel;
    logic [31:0] data;
  } hfl_hub_wr_t;
endpackage

// *** logic/hfl_frame_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// RULE1: frame count advances at each frame reload
// RULE2: frame count wraps FFFF to zero freely
// RULE3: entering running bumps frame count once
// RULE4: post count to shared area before descriptors
// RULE5: raise frame-start flag after the post
// RULE6: low-speed start only if bits-left >= cutoff
// RULE7: cutoff is eleven bits wide
// RULE8: cutoff stays fixed while running
// RULE9: driver computes cutoff including overheads
// RULE10: cutoff read 0x11, written 0x91
// RULE11: hub registers take whole dword accesses only
// RULE12: driver writes hub registers at initialisation
// RULE13: hub descriptors writable in every state
// RULE14: hub status registers writable while running
// RULE15: bits-left decrements per bit, reloads at zero
// RULE16: cutoff resets to 0x628, upper bits zero
module hfl_frame_ctrl (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire hfl_pkg::hfl_cmd_t CMD, // register command, valid for one cycle
  output logic [31:0] RD_DATA, // read answer data
  output logic RD_VALID, // one-cycle pulse with read answer
  input wire logic RUN_STATE, // controller is in running state
  input wire logic [hfl_pkg::FR_W-1:0] FRAME_INTERVAL, // interval value to reload
  output logic SOF_REQ, // request to send the start-of-frame token
  input wire logic SOF_DONE, // token sent
  output logic POST_REQ, // request to write count to shared area
  output logic [hfl_pkg::FN_W-1:0] POST_DATA, // count to be written
  input wire logic POST_ACK, // shared area write finished
  output logic FRAME_START_SET, // one-cycle pulse setting the frame-start flag
  output logic ED_FETCH_OK, // descriptor fetch allowed in this frame
  input wire logic LS_QUERY, // scheduler asks to start a low-speed transaction
  output logic LS_START_OK, // low-speed transaction may start
  output hfl_pkg::hfl_hub_wr_t HUB_WR // accepted hub register write
);
  // frame start sequence states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SOF = 2'b01,
    ST_POST = 2'b10,
    ST_FLAG = 2'b11
  } hfl_state_t;

  logic run_q, run_d; // previous running level for entry detect
  logic run_enter; // pulse on entry to running state
  logic [hfl_pkg::FR_W-1:0] bits_left_in_frame;
  logic [hfl_pkg::FN_W-1:0] frame_count_field;
  logic frame_boundary;
  hfl_state_t st_q, st_d;
  logic [hfl_pkg::FN_W-1:0] post_q, post_d; // captured count for the post
  logic sf_q, sf_d; // frame-start flag set pulse
  logic [hfl_pkg::LSC_W-1:0] lowspeed_cutoff_q, lowspeed_cutoff_d;
  logic [31:0] rd_q, rd_d;
  logic rdv_q, rdv_d;
  hfl_pkg::hfl_hub_wr_t hub_q, hub_d;
  logic hub_ok; // decoded hub write is permitted

  // true when the code is one of the hub register write codes
  function automatic logic is_hub_wr(input logic [7:0] code);
    is_hub_wr = (code >= hfl_pkg::CMD_HUB_DA_WR) && (code <= hfl_pkg::CMD_HUB_P2_WR);
  endfunction

  // frame counter and bits-left counter
  hfl_frame_timer u_timer (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .run_enter(run_enter),
    .running(RUN_STATE),
    .frame_interval_value(FRAME_INTERVAL),
    .bits_left_in_frame(bits_left_in_frame),
    .frame_count_field(frame_count_field),
    .frame_boundary(frame_boundary)
  );

  assign run_enter = RUN_STATE && !run_q;

  // frame start sequence: token, post count, then flag
  always_comb begin
    st_d = st_q;
    post_d = post_q;
    sf_d = 1'b0;
    run_d = RUN_STATE;
    case (st_q)
      ST_IDLE: begin
        // new frame: capture the freshly advanced count
        if (frame_boundary) begin
          post_d = frame_count_field;
          st_d = ST_SOF;
        end
      end
      ST_SOF: begin
        // wait for the token to go out
        if (SOF_DONE) begin
          st_d = ST_POST;
        end
      end
      ST_POST: begin
        // count is written before any descriptor fetch
        if (POST_ACK) begin
          st_d = ST_FLAG; // RULE4
        end
      end
      ST_FLAG: begin
        // written: set the frame-start flag
        sf_d = 1'b1; // RULE5
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (!RUN_STATE) begin
      // leaving running abandons a sequence still waiting on the token or the post
      st_d = ST_IDLE;
    end
  end

  // sequence registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      post_q <= hfl_pkg::FN_RST;
      sf_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      post_q <= post_d;
      sf_q <= sf_d;
      run_q <= run_d;
    end
  end

  // hub writes: descriptors always, status only while running, dword only
  always_comb begin
    if (!CMD.dword) begin
      hub_ok = 1'b0; // RULE11
    end else if (CMD.code == hfl_pkg::CMD_HUB_DA_WR || CMD.code == hfl_pkg::CMD_HUB_DB_WR) begin
      hub_ok = 1'b1; // RULE13
    end else begin
      hub_ok = RUN_STATE; // RULE14
    end
  end

  // register command decode and readback
  always_comb begin
    lowspeed_cutoff_d = lowspeed_cutoff_q;
    rd_d = rd_q;
    rdv_d = 1'b0;
    hub_d = '0;
    if (CMD.valid) begin
      if ((CMD.code & hfl_pkg::CMD_WR_BIT) == 8'h00) begin
        // read: answer next cycle, unmapped codes read zero
        rdv_d = 1'b1;
        case (CMD.code)
          hfl_pkg::CMD_FR_RD: rd_d = {18'h00000, bits_left_in_frame};
          hfl_pkg::CMD_FN_RD: rd_d = {16'h0000, frame_count_field};
          hfl_pkg::CMD_LSC_RD: rd_d = {21'h000000, lowspeed_cutoff_q}; // RULE10 RULE16
          default: rd_d = 32'h00000000;
        endcase
      end else if (CMD.code == hfl_pkg::CMD_LSC_WR) begin
        // cutoff is set up before running and frozen during it
        if (!RUN_STATE) begin
          lowspeed_cutoff_d = CMD.wdata[hfl_pkg::LSC_W-1:0]; // RULE7 RULE8 RULE10
        end
      end else if (is_hub_wr(CMD.code) && hub_ok) begin
        // forward accepted hub write to the root hub block
        hub_d.valid = 1'b1;
        hub_d.sel = 3'(CMD.code - hfl_pkg::CMD_HUB_DA_WR);
        hub_d.data = CMD.wdata;
      end
    end
  end

  // command registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      lowspeed_cutoff_q <= hfl_pkg::LSC_RST; // RULE16
      rd_q <= 32'h00000000;
      rdv_q <= 1'b0;
      hub_q <= '0;
    end else begin
      lowspeed_cutoff_q <= lowspeed_cutoff_d;
      rd_q <= rd_d;
      rdv_q <= rdv_d;
      hub_q <= hub_d;
    end
  end

  assign RD_DATA = rd_q;
  assign RD_VALID = rdv_q;
  assign SOF_REQ = (st_q == ST_SOF);
  assign POST_REQ = (st_q == ST_POST);
  assign POST_DATA = post_q;
  assign FRAME_START_SET = sf_q;
  // the entry cycle already counts as a new frame, so no fetch before its post
  assign ED_FETCH_OK = RUN_STATE && !run_enter && (st_q == ST_IDLE) && !frame_boundary; // RULE4
  // low-speed admission against the cutoff
  assign LS_START_OK = LS_QUERY && RUN_STATE && (bits_left_in_frame >= {3'b000, lowspeed_cutoff_q}); // RULE6
  assign HUB_WR = hub_q;
endmodule

// *** logic/hfl_frame_timer.sv ***
`timescale 1ns/1ps
// bit-time tick, bits-left-in-frame down counter and frame count
module hfl_frame_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_enter, // one-cycle pulse on entry to running state
  input wire logic running, // controller is in running state
  input wire logic [hfl_pkg::FR_W-1:0] frame_interval_value,
  output logic [hfl_pkg::FR_W-1:0] bits_left_in_frame,
  output logic [hfl_pkg::FN_W-1:0] frame_count_field,
  output logic frame_boundary // one-cycle pulse when the frame count advances
);
  logic [15:0] acc_q, acc_d; // phase accumulator for the bit tick
  logic tick_q, tick_d; // one-cycle bit-time enable
  logic [hfl_pkg::FR_W-1:0] fr_q, fr_d;
  logic [hfl_pkg::FN_W-1:0] fn_q, fn_d;
  logic bnd_q, bnd_d;
  logic [16:0] acc_sum; // one bit wider to catch the wrap

  // next-state for divider and counters
  always_comb begin
    acc_sum = {1'b0, acc_q} + {1'b0, hfl_pkg::BIT_ACC_STEP};
    if (acc_sum >= {1'b0, hfl_pkg::BIT_ACC_WRAP}) begin
      acc_d = 16'(acc_sum - {1'b0, hfl_pkg::BIT_ACC_WRAP});
      tick_d = 1'b1;
    end else begin
      acc_d = acc_sum[15:0];
      tick_d = 1'b0;
    end
    fr_d = fr_q;
    fn_d = fn_q;
    bnd_d = 1'b0;
    if (run_enter) begin
      // entering running reloads the interval and bumps the count once
      fr_d = frame_interval_value;
      fn_d = fn_q + 16'h0001; // RULE3
      bnd_d = 1'b1;
    end else if (running && tick_q) begin
      if (fr_q == hfl_pkg::FR_RST) begin
        // zero reached: reload at this bit boundary, which is the frame boundary
        fr_d = frame_interval_value; // RULE15
        fn_d = fn_q + 16'h0001; // RULE1 RULE2
        bnd_d = 1'b1;
      end else begin
        fr_d = fr_q - 14'h0001; // RULE15
      end
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= hfl_pkg::BIT_ACC_RST;
      tick_q <= 1'b0;
      fr_q <= hfl_pkg::FR_RST;
      fn_q <= hfl_pkg::FN_RST;
      bnd_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
      fr_q <= fr_d;
      fn_q <= fn_d;
      bnd_q <= bnd_d;
    end
  end

  assign bits_left_in_frame = fr_q;
  assign frame_count_field = fn_q;
  assign frame_boundary = bnd_q;
endmodule
